/* File: ccb_brownout.sv */
// Brownout detector: level select, disable, crossing event and reset hold
`timescale 1ns/1ns
`default_nettype none
module ccb_brownout (
    input wire logic clk,
    input wire logic sys_rst,
    ccb_if.brownout_disable bif
);
    logic detect_reg;
    logic event_reg;
    logic reset_reg;
    logic below;

    assign below = bif.level_low ? bif.below_low : bif.below_high;
    assign bif.detect = detect_reg;
    assign bif.bod_event = event_reg;
    assign bif.bod_reset = reset_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            detect_reg <= 1'b0;
        end else begin
            detect_reg <= below & ~bif.bod_disable;
        end
    end

    // Only the start of a detection (a falling crossing, or clearing the disable during a sag) makes an event; a long sag gives just one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= below & ~bif.bod_disable & ~detect_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reset_reg <= 1'b0;
        end else begin
            reset_reg <= below & ~bif.bod_disable & ~bif.irq_select;
        end
    end
endmodule // ccb_brownout
`default_nettype wire

/* File: ccb_checker.sv */
// Port checker for the clock and brownout control block
`timescale 1ns/1ns
`default_nettype none
module ccb_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [2:0] cfg_osc_mode,
    input wire logic cfg_compat_clock_halve,
    input wire logic cfg_brownout_level_select,
    input wire logic supply_below_low,
    input wire logic supply_below_high,
    input wire logic osc_first_pin_oe_n,
    input wire logic osc_second_pin_oe_n,
    input wire logic port_first_value,
    input wire logic port_second_value,
    input wire logic cpu_clk_tick,
    input wire logic machine_cycle_tick,
    input wire logic cpu_reset,
    input wire logic brownout_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic below = cfg_brownout_level_select ? supply_below_low : supply_below_high;
    // ----
    // Assertions
    // ----
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero while idle");
    error_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    halve_spacing_a: assert property (cfg_compat_clock_halve && cpu_clk_tick |=> !cpu_clk_tick)
        else $error("cpu ticks too close with halving");
    mcycle_after_tick_a: assert property (machine_cycle_tick |-> $past(cpu_clk_tick))
        else $error("machine tick without cpu tick");
    reset_needs_low_a: assert property (cpu_reset |-> $past(below))
        else $error("cpu reset without low supply");
    reset_or_irq_a: assert property (!(cpu_reset && brownout_irq))
        else $error("reset and interrupt together");
    crystal_pins_off_a: assert property (cfg_osc_mode < 3'h3 |-> osc_first_pin_oe_n && osc_second_pin_oe_n
        && !port_first_value && !port_second_value)
        else $error("oscillator pin used as port in crystal mode");
    cover property (pslverr);
    cover property (cpu_reset);
    cover property (brownout_irq);
    cover property (!osc_second_pin_oe_n);
endmodule // ccb_checker
bind ccb_top ccb_checker chk (.*);
`default_nettype wire

/* File: ccb_clkdiv.sv */
// CPU clock tick generator: compatibility halving and programmable divider
`timescale 1ns/1ns
`default_nettype none
module ccb_clkdiv (
    input wire logic clk,
    input wire logic sys_rst,
    ccb_if.div dif
);
    logic half_phase_reg;
    logic [7:0] active_reg;
    logic [8:0] count_reg;
    logic cpu_tick_reg;
    logic pre_tick;
    logic [8:0] term;

    // Halving stage passes every second oscillator tick
    assign pre_tick = dif.osc_tick & (~dif.halve | half_phase_reg);
    assign term = {active_reg, 1'b1};
    assign dif.cpu_tick = cpu_tick_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            half_phase_reg <= 1'b0;
        end else if (dif.osc_tick) begin
            half_phase_reg <= ~half_phase_reg;
        end
    end

    // Divisor reloads only at wrap, so no tick period is ever shortened
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            active_reg <= ccb_pkg::DIV_RST;
            count_reg <= 9'h000;
            cpu_tick_reg <= 1'b0;
        end else begin
            cpu_tick_reg <= 1'b0;
            if (pre_tick) begin
                if (active_reg == 8'h00 || count_reg == term) begin
                    cpu_tick_reg <= 1'b1;
                    count_reg <= 9'h000;
                    active_reg <= dif.divider;
                end else begin
                    count_reg <= count_reg + 9'h001;
                end
            end
        end
    end
endmodule // ccb_clkdiv
`default_nettype wire

/* File: ccb_if.sv */
// Interface between the control top and its divider and brownout units
`timescale 1ns/1ns
`default_nettype none
interface ccb_if;
    logic osc_tick;
    logic halve;
    logic [7:0] divider;
    logic cpu_tick;
    logic below_low;
    logic below_high;
    logic level_low;
    logic bod_disable;
    logic irq_select;
    logic detect;
    logic bod_event;
    logic bod_reset;
    modport ctrl (output osc_tick, halve, divider, below_low, below_high, level_low,
                  bod_disable, irq_select, input cpu_tick, detect, bod_event, bod_reset);
    modport div (input osc_tick, halve, divider, output cpu_tick);
    modport brownout_disable (input below_low, below_high, level_low, bod_disable, irq_select,
                 output detect, bod_event, bod_reset);
endinterface
`default_nettype wire

/* File: ccb_osc_model.sv */
// External clock source model for the first oscillator pin
`timescale 1ns/1ns
`default_nettype none
module ccb_osc_model #(parameter int HALF = 4) (
    input wire logic clk,
    input wire logic run,
    output logic ext_clk
);
    int cnt = 0;
    // Held low while stopped, as a gated source would be
    always @(posedge clk) begin
        cnt <= (cnt + 1) % HALF;
        ext_clk <= run ? (cnt == 0 ? !ext_clk : ext_clk) : 1'h0;
    end
endmodule // ccb_osc_model
`default_nettype wire

/* File: ccb_pkg.sv */
// Constants and types shared by the clock and brownout control block
package ccb_pkg;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int RC_OSC_FREQ_MHZ = 6;
    localparam logic [7:0] ADDR_DIV = 8'h00;
    localparam logic [7:0] ADDR_AUX = 8'h04;
    localparam logic [7:0] ADDR_IEN = 8'h08;
    localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'h0c;
    localparam logic [7:0] ADDR_PORT2_MODE_REG1 = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam int AUX_IRQ_SEL_BIT = 5;
    localparam int AUX_BOD_DIS_BIT = 6;
    localparam int IEN_GLOBAL_BIT = 7;
    localparam int IEN_BROWNOUT_BIT = 5;
    localparam int POWER_CONTROL_REG_FLAG_BIT = 5;
    localparam int PORT2_MODE_REG1_CLKOUT_BIT = 6;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] PORT2_MODE_REG1_RST = 8'h00;
    localparam logic [2:0] MCYCLE_LAST = 3'h5;
    localparam logic [2:0] CLKOUT_MID = 3'h2;
    typedef enum logic [2:0] {
        OSC_XTAL_LOW = 3'h0,
        OSC_XTAL_MED = 3'h1,
        OSC_XTAL_HIGH = 3'h2,
        OSC_RC = 3'h3,
        OSC_EXT = 3'h4
    } ccb_osc_e;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } ccb_bus_e;
endpackage

/* File: ccb_top.sv */
// Clock source, CPU clock divider, clock output and brownout control with APB registers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module ccb_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [2:0] cfg_osc_mode,
    input wire logic cfg_compat_clock_halve,
    input wire logic cfg_brownout_level_select,
    input wire logic supply_below_low,
    input wire logic supply_below_high,
    input wire logic osc_first_pin_in,
    output logic osc_first_pin_out,
    output logic osc_first_pin_oe_n,
    input wire logic osc_second_pin_in,
    output logic osc_second_pin_out,
    output logic osc_second_pin_oe_n,
    input wire logic port_first_data,
    input wire logic port_first_drive,
    input wire logic port_second_data,
    input wire logic port_second_drive,
    output logic port_first_value,
    output logic port_second_value,
    output logic cpu_clk_tick,
    output logic machine_cycle_tick,
    output logic cpu_reset,
    output logic brownout_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ccb_if cif ();
    ccb_pkg::ccb_bus_e bus_state_reg;
    ccb_pkg::ccb_osc_e osc_mode_reg;
    logic cfg_loaded_reg;
    logic halve_reg;
    logic level_low_reg;
    logic [7:0] cpu_clock_divider_reg;
    logic [7:0] aux_control_reg;
    logic [7:0] irq_enable_reg0;
    logic brownout_flag_reg;
    logic [7:0] port2_mode_reg1;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [6:0] rc_acc_reg;
    logic [6:0] rc_acc_next;
    logic [7:0] rc_sum;
    logic rc_tick;
    logic first_pin_prev_reg;
    logic [2:0] mc_count_reg;
    logic mc_tick_reg;
    logic clock_out_reg;
    logic first_out_reg;
    logic first_oe_n_reg;
    logic second_out_reg;
    logic second_oe_n_reg;
    logic first_val_reg;
    logic second_val_reg;
    logic irq_reg;
    logic wr_en;
    logic rd_hit;
    logic [7:0] rd_byte;
    logic is_xtal;
    logic clkout_allowed;
    logic clkout_active;
    logic first_port_ok;
    logic second_port_ok;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic xtal_mode(input ccb_pkg::ccb_osc_e m);
        xtal_mode = (m == ccb_pkg::OSC_XTAL_LOW) || (m == ccb_pkg::OSC_XTAL_MED) ||
                    (m == ccb_pkg::OSC_XTAL_HIGH);
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == ccb_pkg::ADDR_DIV) || (a == ccb_pkg::ADDR_AUX) ||
                     (a == ccb_pkg::ADDR_IEN) || (a == ccb_pkg::ADDR_POWER_CONTROL_REG) ||
                     (a == ccb_pkg::ADDR_PORT2_MODE_REG1) || (a == ccb_pkg::ADDR_STAT);
    endfunction

    // ----------------------------------------------------------------
    // Configuration straps
    // ----------------------------------------------------------------
    // Straps are sampled once, on the first edge after reset release;
    // nothing on the bus can reach these flops afterwards.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_loaded_reg <= 1'b0;
            osc_mode_reg <= ccb_pkg::OSC_XTAL_HIGH;
            halve_reg <= 1'b0;
            level_low_reg <= 1'b1;
        end else if (!cfg_loaded_reg) begin
            cfg_loaded_reg <= 1'b1;
            case (cfg_osc_mode)
                3'h0: osc_mode_reg <= ccb_pkg::OSC_XTAL_LOW;
                3'h1: osc_mode_reg <= ccb_pkg::OSC_XTAL_MED;
                3'h2: osc_mode_reg <= ccb_pkg::OSC_XTAL_HIGH;
                3'h3: osc_mode_reg <= ccb_pkg::OSC_RC;
                3'h4: osc_mode_reg <= ccb_pkg::OSC_EXT;
                default: osc_mode_reg <= ccb_pkg::OSC_XTAL_HIGH;
            endcase
            halve_reg <= cfg_compat_clock_halve;
            level_low_reg <= cfg_brownout_level_select;
        end
    end

    assign is_xtal = xtal_mode(osc_mode_reg);
    assign clkout_allowed = (osc_mode_reg == ccb_pkg::OSC_RC) ||
                            (osc_mode_reg == ccb_pkg::OSC_EXT);
    assign clkout_active = clkout_allowed & port2_mode_reg1[ccb_pkg::PORT2_MODE_REG1_CLKOUT_BIT];

    // ----------------------------------------------------------------
    // Oscillator tick selection
    // ----------------------------------------------------------------
    // RC source is an average-rate tick from the fast clock: a phase
    // accumulator, so jitter is one fast period, like a real RC.
    // Sum kept one bit wider: accumulator plus step can pass 127
    always_comb begin
        rc_sum = {1'b0, rc_acc_reg} + 8'(ccb_pkg::RC_OSC_FREQ_MHZ);
        rc_acc_next = rc_sum[6:0];
        rc_tick = 1'b0;
        if (rc_sum >= 8'(ccb_pkg::CLK_FREQ_MHZ)) begin
            rc_acc_next = 7'(rc_sum - 8'(ccb_pkg::CLK_FREQ_MHZ));
            rc_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rc_acc_reg <= 7'h00;
        end else begin
            rc_acc_reg <= rc_acc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            first_pin_prev_reg <= 1'b0;
        end else begin
            first_pin_prev_reg <= osc_first_pin_in;
        end
    end

    // Crystal modes treat the fast clock itself as the oscillator
    always_comb begin
        case (osc_mode_reg)
            ccb_pkg::OSC_RC: cif.osc_tick = rc_tick;
            ccb_pkg::OSC_EXT: cif.osc_tick = osc_first_pin_in & ~first_pin_prev_reg;
            default: cif.osc_tick = 1'b1;
        endcase
        // No ticks before the straps load, so halving starts in phase
        if (!cfg_loaded_reg) begin
            cif.osc_tick = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Divider and brownout units
    // ----------------------------------------------------------------
    assign cif.halve = halve_reg;
    assign cif.divider = cpu_clock_divider_reg;
    assign cif.below_low = supply_below_low;
    assign cif.below_high = supply_below_high;
    assign cif.level_low = level_low_reg;
    assign cif.bod_disable = aux_control_reg[ccb_pkg::AUX_BOD_DIS_BIT];
    assign cif.irq_select = aux_control_reg[ccb_pkg::AUX_IRQ_SEL_BIT];

    ccb_clkdiv u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .dif(cif)
    );

    ccb_brownout u_bod (
        .clk(clk),
        .sys_rst(sys_rst),
        .bif(cif)
    );

    // ----------------------------------------------------------------
    // Machine cycle and clock output
    // ----------------------------------------------------------------
    // One counter serves both: timers and the clock output then can
    // never drift apart from the instruction timing.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mc_count_reg <= 3'h0;
            mc_tick_reg <= 1'b0;
        end else begin
            mc_tick_reg <= 1'b0;
            if (cif.cpu_tick) begin
                if (mc_count_reg == ccb_pkg::MCYCLE_LAST) begin
                    mc_count_reg <= 3'h0;
                    mc_tick_reg <= 1'b1;
                end else begin
                    mc_count_reg <= mc_count_reg + 3'h1;
                end
            end
        end
    end

    // Toggles every three CPU ticks; idle does not stop it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_out_reg <= 1'b0;
        end else if (cif.cpu_tick && (mc_count_reg == ccb_pkg::CLKOUT_MID ||
                                      mc_count_reg == ccb_pkg::MCYCLE_LAST)) begin
            clock_out_reg <= ~clock_out_reg;
        end
    end

    // ----------------------------------------------------------------
    // Oscillator pin muxing
    // ----------------------------------------------------------------
    assign first_port_ok = (osc_mode_reg == ccb_pkg::OSC_RC);
    assign second_port_ok = clkout_allowed & ~is_xtal;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            first_out_reg <= 1'b1;
            first_oe_n_reg <= 1'b1;
            first_val_reg <= 1'b0;
        end else begin
            first_out_reg <= port_first_data;
            first_oe_n_reg <= ~(first_port_ok & port_first_drive);
            first_val_reg <= first_port_ok & osc_first_pin_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            second_out_reg <= 1'b1;
            second_oe_n_reg <= 1'b1;
            second_val_reg <= 1'b0;
        end else begin
            if (clkout_active) begin
                second_out_reg <= clock_out_reg;
                second_oe_n_reg <= 1'b0;
            end else begin
                second_out_reg <= port_second_data;
                second_oe_n_reg <= ~(second_port_ok & port_second_drive);
            end
            second_val_reg <= second_port_ok & osc_second_pin_in;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Write commits on the edge that samples pready high, so a stalled
    // master never sees a register change before its transfer ends.
    assign wr_en = (bus_state_reg == ccb_pkg::BUS_RESP) & psel & penable & pwrite &
                   pstrb[0] & addr_known(paddr);
    assign rd_hit = addr_known(paddr);

    always_comb begin
        case (paddr)
            ccb_pkg::ADDR_DIV: rd_byte = cpu_clock_divider_reg;
            ccb_pkg::ADDR_AUX: rd_byte = aux_control_reg;
            ccb_pkg::ADDR_IEN: rd_byte = irq_enable_reg0;
            ccb_pkg::ADDR_POWER_CONTROL_REG: rd_byte = 8'(brownout_flag_reg) << ccb_pkg::POWER_CONTROL_REG_FLAG_BIT;
            ccb_pkg::ADDR_PORT2_MODE_REG1: rd_byte = port2_mode_reg1;
            ccb_pkg::ADDR_STAT: rd_byte = {cpu_reset, cif.detect, level_low_reg, halve_reg,
                                           1'b0, osc_mode_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_state_reg <= ccb_pkg::BUS_IDLE;
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            case (bus_state_reg)
                ccb_pkg::BUS_IDLE: begin
                    if (psel && penable) begin
                        bus_state_reg <= ccb_pkg::BUS_RESP;
                        pready_reg <= 1'b1;
                        pslverr_reg <= ~rd_hit;
                        prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                    end
                end
                ccb_pkg::BUS_RESP: begin
                    bus_state_reg <= ccb_pkg::BUS_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg <= 32'h0000_0000;
                end
                default: begin
                    bus_state_reg <= ccb_pkg::BUS_IDLE;
                    pready_reg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_clock_divider_reg <= ccb_pkg::DIV_RST;
        end else if (wr_en && paddr == ccb_pkg::ADDR_DIV) begin
            cpu_clock_divider_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aux_control_reg <= ccb_pkg::AUX_RST;
        end else if (wr_en && paddr == ccb_pkg::ADDR_AUX) begin
            aux_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_enable_reg0 <= ccb_pkg::IEN_RST;
        end else if (wr_en && paddr == ccb_pkg::ADDR_IEN) begin
            irq_enable_reg0 <= pwdata[7:0];
        end
    end

    // Software may drop the enable before idle to save power
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port2_mode_reg1 <= ccb_pkg::PORT2_MODE_REG1_RST;
        end else if (wr_en && paddr == ccb_pkg::ADDR_PORT2_MODE_REG1) begin
            port2_mode_reg1 <= pwdata[7:0];
        end
    end

    // Write one clears; a detection in the same cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brownout_flag_reg <= 1'b0;
        end else if (cif.bod_event) begin
            brownout_flag_reg <= 1'b1;
        end else if (wr_en && paddr == ccb_pkg::ADDR_POWER_CONTROL_REG &&
                     pwdata[ccb_pkg::POWER_CONTROL_REG_FLAG_BIT]) begin
            brownout_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= brownout_flag_reg & cif.irq_select & ~cif.bod_disable &
                       irq_enable_reg0[ccb_pkg::IEN_GLOBAL_BIT] &
                       irq_enable_reg0[ccb_pkg::IEN_BROWNOUT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign cpu_clk_tick = cif.cpu_tick;
    assign machine_cycle_tick = mc_tick_reg;
    assign cpu_reset = cif.bod_reset;
    assign brownout_irq = irq_reg;
    assign osc_first_pin_out = first_out_reg;
    assign osc_first_pin_oe_n = first_oe_n_reg;
    assign osc_second_pin_out = second_out_reg;
    assign osc_second_pin_oe_n = second_oe_n_reg;
    assign port_first_value = first_val_reg;
    assign port_second_value = second_val_reg;
endmodule // ccb_top
`default_nettype wire

/* File: clock_divider_and_brownout_ctrl_tb.sv */
// Self-checking bench for the clock and brownout control block
`timescale 1ns/1ns
`default_nettype none
module clock_divider_and_brownout_ctrl_tb;
    logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, ext;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] cfg_osc_mode = 3'h0;
    logic cfg_compat_clock_halve = 1'h0, cfg_brownout_level_select = 1'h1, supply_below_low = 1'h0;
    logic supply_below_high = 1'h0, port_first_data = 1'h0, port_first_drive = 1'h0, port_second_data = 1'h0;
    logic port_second_drive = 1'h0, osc_first_pin_out, osc_first_pin_oe_n, osc_second_pin_out, osc_second_pin_oe_n;
    logic port_first_value, port_second_value, cpu_clk_tick, machine_cycle_tick, cpu_reset, brownout_irq;
    logic run = 1'h0;
    logic [32:0] expq[$];
    logic [32:0] note;
    int miscompares = 0, n_tests = 0;
    // Released second pin shows the inverse of its output; released first pin shows the source model
    wire logic osc_first_pin_in = !osc_first_pin_oe_n ? osc_first_pin_out : ext;
    wire logic osc_second_pin_in = !osc_second_pin_oe_n ? osc_second_pin_out : !osc_second_pin_out;
    always #4 clk = !clk;
    ccb_osc_model #(.HALF(4)) src (.clk(clk), .run(run), .ext_clk(ext));
    ccb_top uut (.*);
    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'h1;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        expq.push_back({e, d});
        apb(1'h0, a, 32'h0);
    endtask
    task automatic rst(input logic [2:0] m, input logic h);
        sys_rst <= 1'h1;
        cfg_osc_mode <= m;
        cfg_compat_clock_halve <= h;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
    endtask
    // Period between the second and third event seen
    task automatic per(input int w, input int exp, input string what);
        int t, s, hits;
        logic v, pv;
        t = 0;
        s = 0;
        hits = 0;
        pv = osc_second_pin_out;
        while (hits < 3 && t < 30000) begin
            @(posedge clk);
            t++;
            v = w == 0 ? cpu_clk_tick : w == 1 ? machine_cycle_tick : osc_second_pin_out & !pv;
            pv = osc_second_pin_out;
            if (v === 1'h1) hits++;
            if (v === 1'h1 && hits == 2) s = t;
        end
        chk(what, exp, t - s);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        if (pready === 1'h1 && pwrite === 1'h0) begin
            note = expq.pop_front();
            chk("prdata", note[31:0], prdata);
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
        end
    end
    initial begin
        #800000;
        miscompares++;
        give_verdict();
    end
    initial begin
        logic [7:0] dv[5];
        int q;
        q = $urandom(32'h016b1e72);
        dv = '{8'h00, 8'h01, 8'h00, 8'h00, 8'hff};
        dv[2] = 8'($urandom_range(254, 2));
        rst(3'h0, 1'h0);
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, 1'h0);
        rd(8'h18, 32'h0, 1'h1);
        for (int i = 0; i < 5; i++) begin
            rst(3'h0, 1'(i > 2));
            apb(1'h1, 8'h00, {24'h0, dv[i]});
            rd(8'h00, {24'h0, dv[i]}, 1'h0);
            q = (i > 2 ? 2 : 1) * (dv[i] == 0 ? 1 : 2 * (dv[i] + 1));
            per(0, q, "cpu period");
            per(1, 6 * q, "machine period");
        end
        rst(3'h3, 1'h0);
        port_first_drive <= 1'h1;
        port_first_data <= 1'($urandom);
        repeat (3) @(posedge clk);
        chk("first pin", {31'h0, port_first_data}, {31'h0, osc_first_pin_out});
        chk("first value", {31'h0, port_first_data}, {31'h0, port_first_value});
        run <= 1'h1;
        rst(3'h4, 1'h0);
        apb(1'h1, 8'h10, 32'h40);
        per(2, 48, "clock out period");
        chk("clock out drive", 32'h0, {31'h0, osc_second_pin_oe_n});
        apb(1'h1, 8'h10, 32'h0);
        port_second_drive <= 1'h1;
        port_second_data <= 1'($urandom);
        repeat (3) @(posedge clk);
        chk("port pin", {31'h0, port_second_data}, {31'h0, osc_second_pin_out});
        chk("port value", {31'h0, port_second_data}, {31'h0, port_second_value});
        rst(3'h1, 1'h0);
        apb(1'h1, 8'h10, 32'h40);
        chk("crystal clock out", 32'h1, {31'h0, osc_second_pin_oe_n});
        supply_below_high <= 1'h1;
        repeat (3) @(posedge clk);
        chk("other level reset", 32'h0, {31'h0, cpu_reset});
        supply_below_low <= 1'h1;
        repeat (3) @(posedge clk);
        chk("reset hold", 32'h1, {31'h0, cpu_reset});
        rd(8'h0c, 32'h20, 1'h0);
        apb(1'h1, 8'h0c, 32'h20);
        rd(8'h0c, 32'h0, 1'h0);
        supply_below_low <= 1'h0;
        apb(1'h1, 8'h04, 32'h20);
        apb(1'h1, 8'h08, 32'ha0);
        supply_below_low <= 1'h1;
        repeat (4) @(posedge clk);
        chk("brownout irq", 32'h1, {31'h0, brownout_irq});
        apb(1'h1, 8'h0c, 32'h20);
        repeat (3) @(posedge clk);
        chk("single event", 32'h0, {31'h0, brownout_irq});
        give_verdict();
    end
endmodule // clock_divider_and_brownout_ctrl_tb
`default_nettype wire
